// [src/wfd_detector.sv]
/*
 wfd_detector: scans received frames for the remote wake frame pattern
 and raises a one-cycle wake request after a good frame ends.
 Assumes the MAC gives bytes with a valid strobe on clk_in, marks the
 first and last byte of each frame, and reports the frame check result
 together with the last byte.
*/
`timescale 1ns/100ps
module wfd_detector
    import wfd_pkg::*;
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    // configuration
    input  wire logic        scan_en_in,
    input  wire logic [47:0] station_addr_in,
    // receive byte stream
    input  wire logic        rx_valid_in,
    input  wire logic [7:0]  rx_data_in,
    input  wire logic        rx_sof_in,
    input  wire logic        rx_eof_in,
    input  wire logic        rx_fcs_ok_in,
    // power management
    output logic             wake_req_out,
    output logic             frame_drop_out
);
    import wfd_pkg::*;

    wfd_state_t               state_r;
    wfd_state_t               state_nxt;
    logic [WFD_CNT_W-1:0]     cnt_r;
    logic [WFD_CNT_W-1:0]     cnt_nxt;
    logic [47:0]              da_r;
    logic [2:0]               da_cnt_r;
    logic                     in_frame_r;
    logic [7:0]               exp_byte;
    logic [2:0]               addr_idx;
    logic                     da_ok;
    logic                     found_any;

    // expected station byte: transmitted most significant byte first
    assign addr_idx = 3'((cnt_r - WFD_CNT_W'(WFD_SYNC_LEN)) % WFD_CNT_W'(WFD_ADDR_BYTES));
    assign exp_byte = station_addr_in[8*(5-addr_idx) +: 8];

    // byte-wise scan; the failing byte is re-checked as a possible sync start
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            WFD_IDLE, WFD_SYNC:
            begin
                if (rx_data_in == WFD_SYNC_BYTE)
                begin
                    cnt_nxt   = (cnt_r == WFD_CNT_W'(WFD_SYNC_LEN)) ? cnt_r : cnt_r + 1'b1;
                    state_nxt = WFD_SYNC;
                end
                else if (cnt_r == WFD_CNT_W'(WFD_SYNC_LEN) && rx_data_in == station_addr_in[47:40])
                begin
                    // extra FF bytes keep the run open until the first address byte
                    cnt_nxt   = cnt_r + 1'b1;
                    state_nxt = WFD_ADDR;
                end
                else
                begin
                    cnt_nxt   = '0;
                    state_nxt = WFD_IDLE;
                end
            end
            WFD_ADDR:
            begin
                if (rx_data_in == exp_byte)
                begin
                    cnt_nxt   = cnt_r + 1'b1;
                    state_nxt = (cnt_nxt == WFD_MATCH_LEN) ? WFD_FOUND : WFD_ADDR;
                end
                else if (rx_data_in == WFD_SYNC_BYTE)
                begin
                    cnt_nxt   = WFD_CNT_W'(1);
                    state_nxt = WFD_SYNC;
                end
                else
                begin
                    cnt_nxt   = '0;
                    state_nxt = WFD_IDLE;
                end
            end
            default:
            begin
                state_nxt = WFD_FOUND; // hold until frame end
            end
        endcase
    end

    // scan state register; no protocol parsing, every byte is scanned
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state_r <= WFD_IDLE;
            cnt_r   <= '0;
        end
        else if (!scan_en_in)
        begin
            state_r <= WFD_IDLE;
            cnt_r   <= '0;
        end
        else if (rx_valid_in && (rx_eof_in || rx_sof_in))
        begin
            state_r <= WFD_IDLE; // fresh scan per frame
            cnt_r   <= '0;
            if (rx_sof_in && !rx_eof_in)
            begin
                state_r <= (rx_data_in == WFD_SYNC_BYTE) ? WFD_SYNC : WFD_IDLE;
                cnt_r   <= (rx_data_in == WFD_SYNC_BYTE) ? WFD_CNT_W'(1) : '0;
            end
        end
        else if (rx_valid_in && in_frame_r)
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // frame tracking and destination capture
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            in_frame_r <= 1'b0;
            da_r       <= '0;
            da_cnt_r   <= '0;
        end
        else if (rx_valid_in)
        begin
            in_frame_r <= rx_eof_in ? 1'b0 : (rx_sof_in ? 1'b1 : in_frame_r);
            if (rx_sof_in)
            begin
                da_r     <= {40'h00_0000_0000, rx_data_in};
                da_cnt_r <= 3'h1;
            end
            else if (da_cnt_r != 3'(WFD_DA_BYTES))
            begin
                da_r     <= {da_r[39:0], rx_data_in};
                da_cnt_r <= da_cnt_r + 1'b1;
            end
        end
    end

    // own, multicast (group bit) or broadcast destination
    assign da_ok = (da_cnt_r == 3'(WFD_DA_BYTES)) &&
                   (da_r == station_addr_in || da_r[40] || da_r == WFD_BCAST_ADDR);

    // pattern may complete on the final byte itself
    assign found_any = (state_r == WFD_FOUND) ||
                       (state_r == WFD_ADDR && rx_data_in == exp_byte && cnt_r + 1'b1 == WFD_MATCH_LEN);

    // wake or drop decided only at frame end
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            wake_req_out   <= 1'b0;
            frame_drop_out <= 1'b0;
        end
        else
        begin
            wake_req_out   <= 1'b0;
            frame_drop_out <= 1'b0;
            if (scan_en_in && rx_valid_in && rx_eof_in && in_frame_r)
            begin
                if (found_any && da_ok && rx_fcs_ok_in)
                    wake_req_out <= 1'b1;
                else
                    frame_drop_out <= 1'b1;
            end
        end
    end

    // checks
    property p_wake_at_eof;
        @(posedge clk_in) disable iff (!resetn_in)
        wake_req_out |-> $past(rx_eof_in) && $past(rx_valid_in) && $past(rx_fcs_ok_in);
    endproperty
    a_wake_at_eof: assert property (p_wake_at_eof) else $error("wake without good frame end");

    property p_no_wake_disabled;
        @(posedge clk_in) disable iff (!resetn_in)
        !scan_en_in |=> !wake_req_out;
    endproperty
    a_no_wake_disabled: assert property (p_no_wake_disabled) else $error("wake while scan off");

    property p_exclusive;
        @(posedge clk_in) disable iff (!resetn_in)
        !(wake_req_out && frame_drop_out);
    endproperty
    a_exclusive: assert property (p_exclusive) else $error("wake and drop together");

    property p_pulse;
        @(posedge clk_in) disable iff (!resetn_in)
        wake_req_out |=> !wake_req_out;
    endproperty
    a_pulse: assert property (p_pulse) else $error("wake longer than one cycle");

    property p_needs_pattern;
        @(posedge clk_in) disable iff (!resetn_in)
        wake_req_out |-> $past(found_any) && $past(da_ok);
    endproperty
    a_needs_pattern: assert property (p_needs_pattern) else $error("wake without pattern");

    property p_addr_after_sync;
        @(posedge clk_in) disable iff (!resetn_in)
        (state_r == WFD_ADDR) |-> cnt_r > WFD_CNT_W'(WFD_SYNC_LEN);
    endproperty
    a_addr_after_sync: assert property (p_addr_after_sync) else $error("address scan before sync");

    property p_found_len;
        @(posedge clk_in) disable iff (!resetn_in)
        (state_r == WFD_FOUND) |-> cnt_r == WFD_MATCH_LEN;
    endproperty
    a_found_len: assert property (p_found_len) else $error("found with wrong count");

    property p_eof_outcome;
        @(posedge clk_in) disable iff (!resetn_in)
        (scan_en_in && rx_valid_in && rx_eof_in && in_frame_r) |=> (wake_req_out || frame_drop_out);
    endproperty
    a_eof_outcome: assert property (p_eof_outcome) else $error("frame end without outcome");

    // a sync byte that breaks an address run must open the next sync run at once
    property p_restart;
        @(posedge clk_in) disable iff (!resetn_in)
        (scan_en_in && rx_valid_in && in_frame_r && !rx_sof_in && !rx_eof_in &&
         state_r == WFD_ADDR && rx_data_in == WFD_SYNC_BYTE && rx_data_in != exp_byte)
        |=> (state_r == WFD_SYNC && cnt_r == WFD_CNT_W'(1));
    endproperty
    a_restart: assert property (p_restart) else $error("breaking sync byte not reused");

    c_wake: cover property (@(posedge clk_in) disable iff (!resetn_in) wake_req_out);
    c_drop: cover property (@(posedge clk_in) disable iff (!resetn_in) frame_drop_out);
    c_found: cover property (@(posedge clk_in) disable iff (!resetn_in) state_r == WFD_FOUND);
    c_restart: cover property (@(posedge clk_in) disable iff (!resetn_in)
        state_r == WFD_ADDR && rx_valid_in && rx_data_in == WFD_SYNC_BYTE);
endmodule

// [src/wfd_pkg.sv]
/*
 wfd_pkg: constants shared by the remote wake frame detector.
 Assumes a byte-wide receive stream from the MAC, one byte per strobe.
*/
package wfd_pkg;
    localparam int          WFD_SYNC_LEN    = 6;             // bytes of all ones before the addresses
    localparam int          WFD_ADDR_BYTES  = 6;             // station address length
    localparam int          WFD_ADDR_COPIES = 16;            // back-to-back address copies
    localparam logic [7:0]  WFD_SYNC_BYTE   = 8'hFF;
    localparam logic [47:0] WFD_BCAST_ADDR  = 48'hFFFF_FFFF_FFFF;
    localparam int          WFD_DA_BYTES    = 6;             // destination field length
    localparam int          WFD_CNT_W       = 8;
    localparam logic [WFD_CNT_W-1:0] WFD_MATCH_LEN =
        WFD_CNT_W'(WFD_SYNC_LEN + WFD_ADDR_BYTES * WFD_ADDR_COPIES);

    // scan state; gray along idle -> sync -> addr -> found
    typedef enum logic [1:0] {
        WFD_IDLE  = 2'b00,
        WFD_SYNC  = 2'b01,
        WFD_ADDR  = 2'b11,
        WFD_FOUND = 2'b10
    } wfd_state_t;
endpackage

// [test/testbench.sv]
/*
 testbench: random and corner frames through the detector.
 Assumes the MAC model and the detector share clk_in.
*/
`timescale 1ns/100ps
module testbench;
    import wfd_pkg::*;
    localparam logic [47:0] STA = 48'h0212_3456_789A; // arbitrary station address
    logic [47:0] sta = STA; // station address, changed only between frames
    logic        clk_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic        scan_en_in = 1'b0;
    logic        valid, sof, eof, fcs, wake, drop;
    logic [7:0]  data;
    logic [15:0] rnd = 16'h4B08;
    int          bad_count = 0;
    int          check_count = 0;
    int          cycles = 0;

    always #5 clk_in = ~clk_in;

    wfd_detector wfd_detector_inst (.clk_in(clk_in), .resetn_in(resetn_in), .scan_en_in(scan_en_in),
        .station_addr_in(sta), .rx_valid_in(valid), .rx_data_in(data), .rx_sof_in(sof),
        .rx_eof_in(eof), .rx_fcs_ok_in(fcs), .wake_req_out(wake), .frame_drop_out(drop));
    wfd_mac_model wfd_mac_model_inst (.clk_in(clk_in), .rx_valid_out(valid), .rx_data_out(data),
        .rx_sof_out(sof), .rx_eof_out(eof), .rx_fcs_ok_out(fcs));

    // xorshift source, fixed start
    function automatic logic [15:0] xs();
        rnd = rnd ^ (rnd << 7);
        rnd = rnd ^ (rnd >> 9);
        rnd = rnd ^ (rnd << 8);
        return rnd;
    endfunction

    // {wake, drop}; group bit covers multicast and broadcast
    function automatic logic [1:0] want(logic [47:0] da, int sy, int cp, logic ok, logic en);
        if (!en)
            return 2'b00;
        return ((da == sta || da[40]) && ok && sy >= WFD_SYNC_LEN && cp >= WFD_ADDR_COPIES) ? 2'b10 : 2'b01;
    endfunction

    task automatic check(string name, logic [1:0] seen, logic [1:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %s expected %b seen %b", name, exp, seen);
        end
    endtask

    // frame: DA, SA, filler, broken candidate, sync run, address copies, tail; filler kept below 0x80
    task automatic run(logic [47:0] da, int pre, int sy, int cp, logic ok, string name, int brk = 0);
        logic [7:0] fr[$];
        for (int i = 0; i < 6; i++) fr.push_back(da[47-8*i -: 8]);
        for (int i = 0; i < 6 + pre; i++) fr.push_back(8'(xs() & 16'h007F));
        // broken candidate: full sync and brk copies, cut by the first byte of the real sync
        for (int i = 0; i < (brk > 0 ? WFD_SYNC_LEN : 0); i++) fr.push_back(WFD_SYNC_BYTE);
        for (int i = 0; i < 6 * brk; i++) fr.push_back(sta[47-8*(i%6) -: 8]);
        for (int i = 0; i < sy; i++) fr.push_back(WFD_SYNC_BYTE);
        for (int i = 0; i < 6 * cp; i++) fr.push_back(sta[47-8*(i%6) -: 8]);
        fr.push_back(8'(xs() & 16'h007F));
        wfd_mac_model_inst.send_frame(fr, ok);
        check(name, {wake, drop}, want(da, sy, cp, ok, scan_en_in));
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // hang guard, well beyond the expected few thousand cycles
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            bad_count++;
            print_verdict();
        end
    end

    initial
    begin
        repeat (10) @(negedge clk_in);
        resetn_in = 1'b1;
        run(STA, 0, 6, 16, 1'b1, "idle");
        scan_en_in = 1'b1;
        run(STA, 0, 6, 16, 1'b1, "own");
        run(STA, 9, 7, 16, 1'b0, "bad_fcs");
        run(WFD_BCAST_ADDR, 3, 6, 16, 1'b1, "bcast");
        run(48'h0100_5E00_0001, 30, 6, 16, 1'b1, "mcast");
        run(48'h0A00_0000_0001, 2, 6, 16, 1'b1, "other_da");
        run(STA, 5, 6, 15, 1'b1, "short_copies");
        run(STA, 4, 5, 16, 1'b1, "short_sync");
        run(STA, 1, 8, 17, 1'b1, "extra_ff");
        run(STA, 2, 6, 16, 1'b1, "restart", 3);
        run(STA, 2, 5, 16, 1'b1, "restart_short", 4);
        // random mix of address kinds, offsets, sync lengths and copy counts; second half under a new station address
        for (int n = 0; n < 16; n++)
        begin
            if (n == 8)
                sta = {16'h0234, xs() & 16'h7F7F, xs() & 16'h7F7F}; // unicast, no sync bytes inside
            run(n[0] ? sta : (n[1] ? WFD_BCAST_ADDR : 48'h0A00_0000_0002), xs() % 40,
                5 + xs() % 3, 15 + xs() % 2, xs() % 4 != 0, "random");
        end
        print_verdict();
    end
endmodule

// [test/wfd_mac_model.sv]
/*
 wfd_mac_model: MAC receive side feeding the detector byte by byte.
 Assumes the bench calls send_frame from one process only.
*/
`timescale 1ns/100ps
module wfd_mac_model
(
    // clock
    input  wire logic       clk_in,
    // receive byte stream
    output logic            rx_valid_out,
    output logic [7:0]      rx_data_out,
    output logic            rx_sof_out,
    output logic            rx_eof_out,
    output logic            rx_fcs_ok_out
);
    // quiet stream at time zero
    initial
    begin
        rx_valid_out  = 1'b0;
        rx_data_out   = 8'h00;
        rx_sof_out    = 1'b0;
        rx_eof_out    = 1'b0;
        rx_fcs_ok_out = 1'b0;
    end

    // bytes change at the falling edge; idle data is inverted so a stale byte never matches
    task automatic send_frame(input logic [7:0] q[$], input logic fcs);
        for (int i = 0; i < q.size(); i++)
        begin
            @(negedge clk_in);
            rx_valid_out  = 1'b1;
            rx_data_out   = q[i];
            rx_sof_out    = (i == 0);
            rx_eof_out    = (i == q.size() - 1);
            rx_fcs_ok_out = fcs & rx_eof_out;
        end
        @(negedge clk_in);
        rx_valid_out = 1'b0;
        rx_sof_out   = 1'b0;
        rx_eof_out   = 1'b0;
        rx_data_out  = ~rx_data_out;
    endtask
endmodule
